// *** design/emb_pkg.sv ***
// Shared constants and types for the external memory bus pin logic
`default_nettype none
package emb_pkg;
   // Clock and bus timing
   localparam int CLK_NS = 20;
   localparam int TCY_NS = 160;
   localparam logic [5:0] TCY_CLKS = 6'(TCY_NS / CLK_NS);
   // One data phase lasts half an instruction cycle
   localparam logic [5:0] HALF_TCY_CLKS = 6'(TCY_NS / CLK_NS / 2);

   // Bus control register layout
   localparam int RELEASE_BIT = 7;
   localparam int WAIT_LSB = 4;
   localparam int WCFG_LSB = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_WRITABLE = 8'hb3;

   // Wait field value that adds no wait cycles
   localparam logic [1:0] WAIT_NONE = 2'h3;

   // Program memory modes
   typedef enum logic [1:0] {
      MODE_SINGLE   = 2'h0,
      MODE_BOOT     = 2'h1,
      MODE_EXT_MCU  = 2'h2,
      MODE_EXTERNAL = 2'h3
   } emb_mode_e;

   // Configured address width
   typedef enum logic [1:0] {
      AW_8  = 2'h0,
      AW_12 = 2'h1,
      AW_16 = 2'h2,
      AW_20 = 2'h3
   } emb_aw_e;

   // Decoded 16-bit write configuration
   typedef enum logic [1:0] {
      WC_BYTE_WRITE  = 2'h0,
      WC_BYTE_SELECT = 2'h1,
      WC_WORD_WRITE  = 2'h2
   } emb_wcfg_e;

   // Kind of external access
   typedef enum logic [1:0] {
      K_FETCH = 2'h0,
      K_TRD   = 2'h1,
      K_TWR   = 2'h2
   } emb_kind_e;

   // Bus sequencer states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_ADDR  = 6'h02,
      ST_DATA  = 6'h04,
      ST_DATA2 = 6'h08,
      ST_WAIT  = 6'h10,
      ST_DONE  = 6'h20
   } emb_state_e;
endpackage : emb_pkg
`default_nettype wire

// *** design/emb_sync.sv ***
// Two-stage synchroniser for pin inputs
`default_nettype none
module emb_sync #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d_i;
         q_r <= meta_r;
      end
   end

   assign q_o = q_r;
endmodule // emb_sync
`default_nettype wire

// *** design/emb_bus_ctrl.sv ***
// External memory bus pin ownership, sequencing and write width control
// How it works
// - Single-chip: bus off, pins are ports, control writes refused.
// - Fully external: bus always owns the pins, release bit ignored.
// - Boot/extended: bus for external access, else release bit decides.
// - External access with release bit set takes pins back for the bus.
// - Release set by external code waits until execution goes internal.
// - Idle: data off, strobes/selects high, ALE and byte address low.
// - Idle tri-state touches only lines inside the address width.
// - Bus owns shared pins over every other peripheral.
// - 16-bit writes pick configuration from control bits 1:0.
// - Upper bit set means word write; 01 means byte select.
// - 16-bit: ALE with address, then read strobe for the whole word.
// - Chip select low during accesses, high in sleep.
// - Byte write: latch on both halves, high or low strobe by LSB.
// - Word write even: keep latch, tri-state data, no strobe.
// - Word write odd: latch on upper byte, held byte on lower.
// - Word write: high strobe only, LSB on byte address, both selects.
// - Byte select: latch on both halves, high strobe, byte by LSB.
// - 8-bit width: data shares the low eight address lines.
// - 8-bit fetch: two bytes per cycle, byte address toggles between.
// - 8-bit: latch strobe marks address bits 15:0 valid.
// - 8-bit table write drives byte address from pointer LSB.
// - Wait field 11/10/01/00 adds 0/1/2/3 cycles to table operations.
// - Sleep/idle: freeze pins, chip and byte selects high.
`default_nettype none
module emb_bus_ctrl (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Configuration straps and power state
   input wire emb_pkg::emb_mode_e prog_mode_i,
   input wire emb_pkg::emb_aw_e addr_width_i,
   input wire logic data_width16_i,
   input wire logic sleep_i,
   input wire logic exec_external_i,
   // Bus control register write port
   input wire logic bus_ctrl_wr_i,
   input wire logic [7:0] bus_ctrl_wdata_i,
   output logic [7:0] bus_control_register_o,
   // Core access request and answer
   input wire logic req_valid_i,
   input wire emb_pkg::emb_kind_e req_kind_i,
   input wire logic [20:0] table_pointer_i,
   input wire logic [7:0] table_data_latch_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic [15:0] rsp_data_o,
   // Multiplexed address/data pins
   input wire logic [15:0] ad_in_i,
   output logic [15:0] ad_out_o,
   output logic [15:0] ad_oe_n_o,
   output logic [3:0] addr_hi_out_o,
   output logic [3:0] addr_hi_oe_n_o,
   // Pin ownership towards port and peripheral muxes
   output logic [19:0] pin_is_bus_o,
   output logic ctrl_is_bus_o,
   // Control pins
   output logic ale_o,
   output logic read_strobe_n_o,
   output logic write_strobe_high_n_o,
   output logic write_strobe_low_n_o,
   output logic byte_address_lsb_o,
   output logic chip_select_n_o,
   output logic upper_byte_select_n_o,
   output logic lower_byte_select_n_o
);
   import emb_pkg::*;

   function automatic emb_wcfg_e wcfg_decode(input logic [1:0] f);
      if (f[1]) return WC_WORD_WRITE;
      else if (f[0]) return WC_BYTE_SELECT;
      else return WC_BYTE_WRITE;
   endfunction

   function automatic logic [5:0] wait_clks(input logic [1:0] f);
      return 6'((WAIT_NONE - f) * TCY_CLKS);
   endfunction

   function automatic logic [15:0] merge_read(input logic [15:0] old,
         input logic [15:0] pins, input logic dw16);
      return dw16 ? pins : {old[15:8], pins[7:0]};
   endfunction

   logic [15:0] ad_sync;
   emb_sync #(.W(16)) u_ad_sync (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .d_i(ad_in_i),
      .q_o(ad_sync)
   );

   // Control register and effective release bit
   logic [7:0] ctrl_r, ctrl_nxt;
   logic release_r, release_nxt;
   emb_wcfg_e wcfg;

   always_comb begin
      ctrl_nxt = ctrl_r;
      if (bus_ctrl_wr_i && prog_mode_i != MODE_SINGLE) begin
         ctrl_nxt = bus_ctrl_wdata_i & CTRL_WRITABLE;
      end
      // Setting only lands once code runs internally; clearing is instant
      if (!ctrl_r[RELEASE_BIT]) release_nxt = 1'b0;
      else if (!exec_external_i) release_nxt = 1'b1;
      else release_nxt = release_r;
      wcfg = wcfg_decode(ctrl_r[WCFG_LSB +: 2]);
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctrl_r <= CTRL_RESET;
         release_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         release_r <= release_nxt;
      end
   end

   // Access sequencer
   emb_state_e state_r, state_nxt;
   emb_kind_e kind_r, kind_nxt;
   logic [5:0] cnt_r, cnt_nxt;
   logic [20:0] addr_r, addr_nxt;
   logic [7:0] wdata_r, wdata_nxt, hold_r, hold_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic ready_r, ready_nxt, rsp_valid_r, rsp_valid_nxt;
   logic take;

   assign take = req_valid_i && ready_r && !sleep_i;

   always_comb begin
      state_nxt = state_r;
      kind_nxt = kind_r;
      cnt_nxt = cnt_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      hold_nxt = hold_r;
      rdata_nxt = rdata_r;
      rsp_valid_nxt = 1'b0;
      // Sleep suspends the sequencer where it stands
      if (!sleep_i) begin
         case (state_r)
            ST_IDLE: begin
               if (take) begin
                  kind_nxt = req_kind_i;
                  addr_nxt = table_pointer_i;
                  wdata_nxt = table_data_latch_i;
                  state_nxt = ST_ADDR;
               end
            end
            ST_ADDR: begin
               cnt_nxt = HALF_TCY_CLKS - 6'h01;
               state_nxt = ST_DATA;
               if (kind_r == K_TWR && data_width16_i &&
                     wcfg == WC_WORD_WRITE && !addr_r[0]) begin
                  hold_nxt = wdata_r;
               end
            end
            ST_DATA: begin
               if (cnt_r != 6'h00) begin
                  cnt_nxt = cnt_r - 6'h01;
               end else begin
                  rdata_nxt = merge_read(rdata_r, ad_sync, data_width16_i);
                  if (kind_r == K_FETCH && !data_width16_i) begin
                     cnt_nxt = HALF_TCY_CLKS - 6'h01;
                     state_nxt = ST_DATA2;
                  end else if (kind_r != K_FETCH &&
                        wait_clks(ctrl_r[WAIT_LSB +: 2]) != 6'h00) begin
                     cnt_nxt = wait_clks(ctrl_r[WAIT_LSB +: 2]) - 6'h01;
                     state_nxt = ST_WAIT;
                  end else begin
                     state_nxt = ST_DONE;
                  end
               end
            end
            ST_DATA2: begin
               if (cnt_r != 6'h00) begin
                  cnt_nxt = cnt_r - 6'h01;
               end else begin
                  rdata_nxt = {ad_sync[7:0], rdata_r[7:0]};
                  state_nxt = ST_DONE;
               end
            end
            ST_WAIT: begin
               if (cnt_r != 6'h00) begin
                  cnt_nxt = cnt_r - 6'h01;
               end else begin
                  // Slow memories settle late; take the last sample
                  rdata_nxt = merge_read(rdata_r, ad_sync, data_width16_i);
                  state_nxt = ST_DONE;
               end
            end
            ST_DONE: begin
               rsp_valid_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
         endcase
      end
      ready_nxt = state_nxt == ST_IDLE && !sleep_i &&
            prog_mode_i != MODE_SINGLE;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_r <= ST_IDLE;
         kind_r <= K_FETCH;
         cnt_r <= 6'h00;
         addr_r <= '0;
         wdata_r <= 8'h00;
         hold_r <= 8'h00;
         rdata_r <= 16'h0000;
         ready_r <= 1'b0;
         rsp_valid_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         kind_r <= kind_nxt;
         cnt_r <= cnt_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         hold_r <= hold_nxt;
         rdata_r <= rdata_nxt;
         ready_r <= ready_nxt;
         rsp_valid_r <= rsp_valid_nxt;
      end
   end

   // Pin drive, computed from the next state so pins track state_r
   logic [15:0] ad_r, ad_nxt, ad_oe_n_r, ad_oe_n_nxt;
   logic [3:0] ahi_r, ahi_nxt, ahi_oe_n_r, ahi_oe_n_nxt;
   logic [19:0] own_r, own_nxt, width_mask;
   logic cbus_r, cbus_nxt, owned;
   logic ale_r, ale_nxt, rd_n_r, rd_n_nxt, wrh_n_r, wrh_n_nxt;
   logic wrl_n_r, wrl_n_nxt, ba_r, ba_nxt, cs_n_r, cs_n_nxt;
   logic ub_n_r, ub_n_nxt, lb_n_r, lb_n_nxt;
   logic busy, is_wr;

   always_comb begin
      busy = state_nxt != ST_IDLE && state_nxt != ST_DONE;
      is_wr = kind_nxt == K_TWR;
      case (addr_width_i)
         AW_8: width_mask = 20'h000ff;
         AW_12: width_mask = 20'h00fff;
         AW_16: width_mask = 20'h0ffff;
         default: width_mask = 20'hfffff;
      endcase
      case (prog_mode_i)
         MODE_SINGLE: owned = 1'b0;
         MODE_EXTERNAL: owned = 1'b1;
         default: owned = busy || !release_nxt;
      endcase
      // Idle pin levels
      ad_nxt = ad_r;
      ad_oe_n_nxt = 16'hffff;
      ahi_nxt = ahi_r;
      ahi_oe_n_nxt = 4'hf;
      ale_nxt = 1'b0;
      rd_n_nxt = 1'b1;
      wrh_n_nxt = 1'b1;
      wrl_n_nxt = 1'b1;
      ba_nxt = 1'b0;
      cs_n_nxt = 1'b1;
      ub_n_nxt = 1'b1;
      lb_n_nxt = 1'b1;
      if (state_nxt == ST_ADDR) begin
         ale_nxt = 1'b1;
         cs_n_nxt = 1'b0;
         ad_nxt = addr_nxt[16:1];
         ad_oe_n_nxt = 16'h0000;
         ahi_nxt = addr_nxt[20:17];
         ahi_oe_n_nxt = 4'h0;
         ba_nxt = addr_nxt[0];
      end else if (busy) begin
         cs_n_nxt = 1'b0;
         ahi_oe_n_nxt = 4'h0;
         ba_nxt = state_nxt == ST_DATA2 ? 1'b1 : addr_nxt[0];
         if (!data_width16_i) begin
            // Upper lines stay address-only in 8-bit width
            ad_oe_n_nxt[15:8] = 8'h00;
            if (is_wr) begin
               ad_nxt[7:0] = wdata_nxt;
               ad_oe_n_nxt[7:0] = 8'h00;
               wrl_n_nxt = 1'b0;
               ba_nxt = addr_nxt[0];
            end else begin
               rd_n_nxt = 1'b0;
            end
         end else if (!is_wr) begin
            rd_n_nxt = 1'b0;
            ub_n_nxt = 1'b0;
            lb_n_nxt = 1'b0;
         end else begin
            case (wcfg)
               WC_WORD_WRITE: begin
                  ub_n_nxt = 1'b0;
                  lb_n_nxt = 1'b0;
                  if (addr_nxt[0]) begin
                     ad_nxt = {wdata_nxt, hold_nxt};
                     ad_oe_n_nxt = 16'h0000;
                     wrh_n_nxt = 1'b0;
                  end
               end
               WC_BYTE_SELECT: begin
                  ad_nxt = {wdata_nxt, wdata_nxt};
                  ad_oe_n_nxt = 16'h0000;
                  wrh_n_nxt = 1'b0;
                  ub_n_nxt = !addr_nxt[0];
                  lb_n_nxt = addr_nxt[0];
               end
               default: begin
                  ad_nxt = {wdata_nxt, wdata_nxt};
                  ad_oe_n_nxt = 16'h0000;
                  wrh_n_nxt = !addr_nxt[0];
                  wrl_n_nxt = addr_nxt[0];
               end
            endcase
         end
      end
      // Bus wins the shared pins over ports and peripherals
      own_nxt = owned ? width_mask : 20'h00000;
      cbus_nxt = owned;
      ad_oe_n_nxt = ad_oe_n_nxt | ~own_nxt[15:0];
      ahi_oe_n_nxt = ahi_oe_n_nxt | ~own_nxt[19:16];
      if (sleep_i) begin
         // Frozen pins keep the memory quiet without losing its address
         ad_nxt = ad_r;
         ad_oe_n_nxt = ad_oe_n_r;
         ahi_nxt = ahi_r;
         ahi_oe_n_nxt = ahi_oe_n_r;
         own_nxt = own_r;
         cbus_nxt = cbus_r;
         ale_nxt = ale_r;
         rd_n_nxt = rd_n_r;
         wrh_n_nxt = wrh_n_r;
         wrl_n_nxt = wrl_n_r;
         ba_nxt = ba_r;
         cs_n_nxt = 1'b1;
         ub_n_nxt = 1'b1;
         lb_n_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ad_r <= 16'h0000;
         ad_oe_n_r <= 16'hffff;
         ahi_r <= 4'h0;
         ahi_oe_n_r <= 4'hf;
         own_r <= 20'h00000;
         cbus_r <= 1'b0;
         ale_r <= 1'b0;
         rd_n_r <= 1'b1;
         wrh_n_r <= 1'b1;
         wrl_n_r <= 1'b1;
         ba_r <= 1'b0;
         cs_n_r <= 1'b1;
         ub_n_r <= 1'b1;
         lb_n_r <= 1'b1;
      end else begin
         ad_r <= ad_nxt;
         ad_oe_n_r <= ad_oe_n_nxt;
         ahi_r <= ahi_nxt;
         ahi_oe_n_r <= ahi_oe_n_nxt;
         own_r <= own_nxt;
         cbus_r <= cbus_nxt;
         ale_r <= ale_nxt;
         rd_n_r <= rd_n_nxt;
         wrh_n_r <= wrh_n_nxt;
         wrl_n_r <= wrl_n_nxt;
         ba_r <= ba_nxt;
         cs_n_r <= cs_n_nxt;
         ub_n_r <= ub_n_nxt;
         lb_n_r <= lb_n_nxt;
      end
   end

   assign bus_control_register_o = ctrl_r;
   assign req_ready_o = ready_r;
   assign rsp_valid_o = rsp_valid_r;
   assign rsp_data_o = rdata_r;
   assign ad_out_o = ad_r;
   assign ad_oe_n_o = ad_oe_n_r;
   assign addr_hi_out_o = ahi_r;
   assign addr_hi_oe_n_o = ahi_oe_n_r;
   assign pin_is_bus_o = own_r;
   assign ctrl_is_bus_o = cbus_r;
   assign ale_o = ale_r;
   assign read_strobe_n_o = rd_n_r;
   assign write_strobe_high_n_o = wrh_n_r;
   assign write_strobe_low_n_o = wrl_n_r;
   assign byte_address_lsb_o = ba_r;
   assign chip_select_n_o = cs_n_r;
   assign upper_byte_select_n_o = ub_n_r;
   assign lower_byte_select_n_o = lb_n_r;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   sequence s_data_end;
      state_r == ST_DATA && cnt_r == 6'h00 && !sleep_i;
   endsequence
   sequence s_table_op;
      kind_r != K_FETCH;
   endsequence

   AST_SINGLE_NO_BUS: assert property (
      prog_mode_i == MODE_SINGLE ##1 prog_mode_i == MODE_SINGLE
      |-> !ctrl_is_bus_o && pin_is_bus_o == 20'h00000 && !req_ready_o)
      else $error("bus active in single-chip mode");
   AST_SINGLE_NO_WRITE: assert property (
      prog_mode_i == MODE_SINGLE && bus_ctrl_wr_i
      |=> $stable(bus_control_register_o))
      else $error("control register written in single-chip mode");
   AST_EXT_ALWAYS_BUS: assert property (
      prog_mode_i == MODE_EXTERNAL && !sleep_i
      |=> ctrl_is_bus_o)
      else $error("fully external mode lost the bus");
   AST_TAKE_BUS: assert property (
      take |=> ctrl_is_bus_o && ale_o && !chip_select_n_o
      ##1 !read_strobe_n_o || kind_r == K_TWR || sleep_i)
      else $error("access did not claim bus with latch strobe");
   AST_DEFER_RELEASE: assert property (
      exec_external_i && !release_r |=> !release_r)
      else $error("release took effect during external execution");
   AST_IDLE_PINS: assert property (
      state_r == ST_IDLE && ctrl_is_bus_o && !sleep_i && !$past(sleep_i)
      |-> chip_select_n_o && read_strobe_n_o && write_strobe_high_n_o
      && write_strobe_low_n_o && !ale_o && !byte_address_lsb_o
      && ad_oe_n_o == 16'hffff)
      else $error("idle bus pins not at rest levels");
   AST_WORD_EVEN: assert property (
      state_r == ST_DATA && kind_r == K_TWR && data_width16_i
      && wcfg == WC_WORD_WRITE && !addr_r[0] && !sleep_i
      |-> write_strobe_high_n_o && write_strobe_low_n_o
      && ad_oe_n_o == 16'hffff)
      else $error("even word write drove the bus");
   AST_NO_WAIT: assert property (
      s_data_end and s_table_op and ctrl_r[5:4] == 2'h3
      |=> state_r == ST_DONE)
      else $error("wait added with wait field 11");
   AST_ONE_WAIT: assert property (
      s_data_end and s_table_op and ctrl_r[5:4] == 2'h2
      and !sleep_i[*1] |=> (state_r == ST_WAIT && !sleep_i)[*8]
      ##1 state_r == ST_DONE or sleep_i)
      else $error("wait field 10 did not add one cycle");
   AST_SLEEP_SELECTS: assert property (
      sleep_i |=> chip_select_n_o && upper_byte_select_n_o
      && lower_byte_select_n_o)
      else $error("selects not high in sleep");
   AST_8BIT_TOGGLE: assert property (
      s_data_end and kind_r == K_FETCH and !data_width16_i
      |=> state_r == ST_DATA2 && byte_address_lsb_o && !read_strobe_n_o)
      else $error("8-bit fetch second byte missing");
   AST_8BIT_WR_BA: assert property (
      state_r == ST_DATA && kind_r == K_TWR && !data_width16_i
      && !sleep_i && !$past(sleep_i)
      |-> byte_address_lsb_o == addr_r[0] && !write_strobe_low_n_o)
      else $error("8-bit table write byte address wrong");
endmodule // emb_bus_ctrl
`default_nettype wire

// *** verification/emb_mem_model.sv ***
// Behavioural external memory answering reads on the multiplexed pins
`default_nettype none
module emb_mem_model (
   // Clock
   input wire logic clk_i,
   // Bus pins from the device
   input wire logic [15:0] ad_out_i,
   input wire logic ale_i,
   input wire logic rd_n_i,
   input wire logic ba_i,
   input wire logic dw16_i,
   // Data back to the device
   output logic [15:0] ad_in_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] addr_r = 16'h0000;
   logic [15:0] inv_r = 16'h0000;
   logic [15:0] word;
   assign word = addr_r ^ 16'ha5c3;
   // Released bus shows a pattern inverted every clock, so the last data returns every other cycle
   always_comb begin
      if (rd_n_i === 1'b0) begin
         // Byte address picks the half in 8-bit width
         ad_in_o = dw16_i ? word
               : {8'h00, ba_i ? word[15:8] : word[7:0]};
      end else begin
         ad_in_o = inv_r;
      end
   end
   always @(posedge clk_i) begin
      inv_r <= ~ad_in_o;
      if (ale_i === 1'b1) begin
         addr_r <= ad_out_i;
      end
   end
endmodule // emb_mem_model
`default_nettype wire

// *** verification/tb_emb_bus_ctrl.sv ***
// Self-checking bench for the external memory bus pin logic
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
   num_errors++; $display("unexpected %0t %h %h", $time, g, e); end end
module tb_emb_bus_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   import emb_pkg::*;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   emb_mode_e prog_mode_i = MODE_SINGLE;
   emb_aw_e addr_width_i = AW_16;
   emb_kind_e req_kind_i = K_FETCH;
   logic data_width16_i = 1'b1, sleep_i = 1'b0, exec_external_i = 1'b0;
   logic bus_ctrl_wr_i = 1'b0, req_valid_i = 1'b0;
   logic [7:0] bus_ctrl_wdata_i = 8'h00, table_data_latch_i = 8'h00;
   logic [20:0] table_pointer_i = 21'h0;
   logic [7:0] bus_control_register_o;
   logic req_ready_o, rsp_valid_o, ctrl_is_bus_o, ale_o, read_strobe_n_o;
   logic write_strobe_high_n_o, write_strobe_low_n_o, byte_address_lsb_o;
   logic chip_select_n_o, upper_byte_select_n_o, lower_byte_select_n_o;
   logic [15:0] rsp_data_o, ad_in_i, ad_out_o, ad_oe_n_o;
   logic [3:0] addr_hi_out_o, addr_hi_oe_n_o;
   logic [19:0] pin_is_bus_o, wo;
   logic [43:0] idle_w;
   logic [23:0] rq[$];
   logic [19:0] wq[$];
   int num_errors = 0, comparisons = 0, cyc = 0, tk = 0;
   logic wr_on = 1'b0;
   logic [15:0] rnd = 16'h0007;
   logic [20:0] p;
   logic [7:0] d, h;
   assign wo = {write_strobe_high_n_o, write_strobe_low_n_o,
      upper_byte_select_n_o, lower_byte_select_n_o, ad_out_o};
   assign idle_w = {pin_is_bus_o, ad_oe_n_o, chip_select_n_o,
      read_strobe_n_o, wo[19:16], ale_o, byte_address_lsb_o};
   emb_bus_ctrl u_dut (.clk_i, .srst_i, .prog_mode_i, .addr_width_i,
      .data_width16_i, .sleep_i, .exec_external_i, .bus_ctrl_wr_i,
      .bus_ctrl_wdata_i, .bus_control_register_o, .req_valid_i, .req_kind_i,
      .table_pointer_i, .table_data_latch_i, .req_ready_o, .rsp_valid_o,
      .rsp_data_o, .ad_in_i, .ad_out_o, .ad_oe_n_o, .addr_hi_out_o,
      .addr_hi_oe_n_o, .pin_is_bus_o, .ctrl_is_bus_o, .ale_o,
      .read_strobe_n_o, .write_strobe_high_n_o, .write_strobe_low_n_o,
      .byte_address_lsb_o, .chip_select_n_o, .upper_byte_select_n_o,
      .lower_byte_select_n_o);
   emb_mem_model u_mem (.clk_i, .ad_out_i(ad_out_o), .ale_i(ale_o),
      .rd_n_i(read_strobe_n_o), .ba_i(byte_address_lsb_o),
      .dw16_i(data_width16_i), .ad_in_o(ad_in_i));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [15:0] mw(input logic [20:0] a);
      return a[16:1] ^ 16'ha5c3;
   endfunction
   task automatic report_and_stop();
      if (num_errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic rst(input emb_mode_e m, input emb_aw_e aw, input logic w);
      @(posedge clk_i);
      srst_i <= 1'b1;
      prog_mode_i <= m;
      addr_width_i <= aw;
      data_width16_i <= w;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic wreg(input logic [7:0] v);
      @(posedge clk_i);
      bus_ctrl_wr_i <= 1'b1;
      bus_ctrl_wdata_i <= v;
      @(posedge clk_i);
      bus_ctrl_wr_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   // Request held until the edge that samples ready high
   task automatic issue(input emb_kind_e k, input logic [20:0] a,
         input logic [7:0] v, input logic [23:0] n);
      rq.push_back(n);
      @(posedge clk_i);
      while (req_ready_o !== 1'b1) @(posedge clk_i);
      req_valid_i <= 1'b1;
      req_kind_i <= k;
      table_pointer_i <= a;
      table_data_latch_i <= v;
      @(posedge clk_i);
      tk = cyc;
      req_valid_i <= 1'b0;
      while (rq.size() != 0) @(posedge clk_i);
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   // Result watcher: oldest note against each answer or write strobe
   always @(posedge clk_i) begin
      if (rsp_valid_o === 1'b1 && rq.size() != 0) begin
         `CHK(7'(cyc - tk), rq[0][22:16])
         if (rq[0][23]) `CHK(rsp_data_o, rq[0][15:0])
         void'(rq.pop_front());
      end
      if (!wr_on && wo[19:18] !== 2'b11) begin
         `CHK(wo, wq[0])
         if (wq.size() != 0) void'(wq.pop_front());
      end
      wr_on <= (wo[19:18] != 2'b11);
   end
   initial begin
      rst(MODE_SINGLE, AW_16, 1'b1);
      wreg(8'hff);
      `CHK(bus_control_register_o, 8'h00)
      `CHK({pin_is_bus_o, ctrl_is_bus_o, req_ready_o}, 22'h0)
      rst(MODE_EXTERNAL, AW_20, 1'b1);
      wreg(8'hff);
      `CHK(bus_control_register_o, 8'hb3)
      `CHK(pin_is_bus_o, 20'hfffff)
      rst(MODE_BOOT, AW_16, 1'b1);
      `CHK(idle_w, {20'h0ffff, 16'hffff, 8'hfc})
      exec_external_i <= 1'b1;
      wreg(8'hb0);
      `CHK(pin_is_bus_o, 20'h0ffff)
      exec_external_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CHK(pin_is_bus_o, 20'h0)
      rnd = lfsr(rnd);
      fork
         issue(K_FETCH, {5'h0, rnd}, 8'h00, {1'b1, 7'd7, mw({5'h0, rnd})});
         begin
            repeat (4) @(posedge clk_i);
            `CHK(pin_is_bus_o, 20'h0ffff)
            `CHK({addr_hi_out_o, addr_hi_oe_n_o}, 8'h0f)
         end
      join
      for (int w = 0; w < 4; w++) begin
         wreg({2'b00, 2'(w), 4'h0});
         rnd = lfsr(rnd);
         p = {5'h0, rnd};
         issue(K_TRD, p, 8'h00, {1'b1, 7'(31 - 8 * w), mw(p)});
      end
      for (int m = 0; m < 3; m++) begin
         wreg({4'h3, 2'b00, 2'(m)});
         rnd = lfsr(rnd);
         for (int b = 0; b < 2; b++) begin
            p = {5'h0, rnd[15:1], 1'(b)};
            d = 8'(rnd + 16'(b));
            case (m)
               0: wq.push_back({b ? 4'h7 : 4'hb, d, d});
               1: wq.push_back({b ? 4'h5 : 4'h6, d, d});
               default: if (b) wq.push_back({4'h4, d, h}); else h = d;
            endcase
            issue(K_TWR, p, d, {1'b0, 7'd7, 16'h0});
         end
      end
      sleep_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK(wo[17:16], 2'h3)
      `CHK({chip_select_n_o, req_ready_o}, 2'h2)
      sleep_i <= 1'b0;
      rst(MODE_EXT_MCU, AW_16, 1'b0);
      rnd = lfsr(rnd);
      // Instructions sit on even byte addresses
      p = {5'h0, rnd[15:1], 1'b0};
      issue(K_FETCH, p, 8'h00, {1'b1, 7'd11, mw(p)});
      // Odd pointer; reset wait field 00 adds 24 cycles
      p = {5'h0, rnd[14:0], 1'b1};
      d = 8'(rnd);
      wq.push_back({4'hb, p[16:9], d});
      issue(K_TWR, p, d, {1'b0, 7'd31, 16'h0});
      report_and_stop();
   end
endmodule // tb_emb_bus_ctrl
`default_nettype wire
